// ### shared/opc_pkg.sv
package opc_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned FILT_STEP_NS = 25;
    // least time, rounded up, never below one cycle
    localparam int unsigned FILT_STEP_RAW = (FILT_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned FILT_STEP_CYC = (FILT_STEP_RAW < 1) ? 1 : FILT_STEP_RAW;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_INP_PWR = 8'h1E;
    localparam logic [7:0] OFS_OUT_FMT = 8'h1F;
    localparam logic [7:0] OFS_CLK_SYNC = 8'h20;
    localparam logic [7:0] OFS_RSV_CFG = 8'h21;
    localparam logic [7:0] OFS_FILT_WIN = 8'h23;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_INP_PWR = 8'h20;
    localparam logic [7:0] RST_OUT_FMT = 8'h94;
    localparam logic [7:0] RST_CLK_SYNC = 8'h08;
    localparam logic [7:0] RST_RSV_CFG = 8'h00;
    localparam logic [7:0] RST_FILT_WIN = 8'h0A;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int unsigned B_PD_AUTO = 4;
    localparam int unsigned B_PD_BIT = 3;
    localparam int unsigned B_PD_POL = 2;
    localparam int unsigned B_PD_FAST = 1;
    localparam int unsigned B_GS_PDTRI = 0;
    localparam int unsigned B_FMT_HI = 7;
    localparam int unsigned B_FMT_LO = 5;
    localparam int unsigned B_PRI_EN = 4;
    localparam int unsigned B_SEC_EN = 3;
    localparam int unsigned B_DRV_HI = 2;
    localparam int unsigned B_DRV_LO = 1;
    localparam int unsigned B_CLK_INV = 0;
    localparam int unsigned B_CKS_HI = 7;
    localparam int unsigned B_CKS_LO = 6;
    localparam int unsigned B_ALL_HIZ = 5;
    localparam int unsigned B_GS_HIZ = 4;
    localparam int unsigned B_FLD_POL = 3;
    localparam int unsigned B_PLL_FILT = 2;
    localparam int unsigned B_SP_REGEN = 1;

    // ----------------------------------------
    // sampled pin slots
    // ----------------------------------------
    localparam int unsigned PIN_PD = 0;
    localparam int unsigned PIN_PCLK = 1;
    localparam int unsigned PIN_P90 = 2;
    localparam int unsigned PIN_P2X = 3;
    localparam int unsigned PIN_RAWHS = 4;
    localparam int unsigned PIN_REGHS = 5;
    localparam int unsigned PIN_FIELD = 6;
    localparam int unsigned PIN_GSYNC = 7;
    localparam int unsigned PIN_N = 8;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        OPC_FMT_444 = 3'b100,
        OPC_FMT_422 = 3'b101,
        OPC_FMT_DDR = 3'b110
    } opc_fmt_e;

    typedef enum logic [1:0] {
        OPC_CK_PIX = 2'b00,
        OPC_CK_P90 = 2'b01,
        OPC_CK_P2X = 2'b10,
        OPC_CK_INT = 2'b11
    } opc_cksel_e;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } opc_pix_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } opc_bus_s;
endpackage

// ### core/opc_ctrl.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module opc_ctrl
    import opc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register port
    input wire opc_pkg::opc_bus_s reg_bus,
    output logic [7:0] rdata_q,
    // pins and chip-side inputs
    input wire logic [opc_pkg::PIN_N-1:0] pins,
    input wire logic auto_pd,
    input wire opc_pkg::opc_pix_s pix_a,
    input wire opc_pkg::opc_pix_s pix_b,
    // pixel outputs
    output opc_pkg::opc_pix_s pix_out_q,
    output logic pri_oe_q,
    output logic sec_oe_q,
    output logic [1:0] drive_q,
    // clock and sync outputs
    output logic clk_out_q,
    output logic clk_oe_q,
    output logic green_sync_out_q,
    output logic green_sync_oe_q,
    output logic field_out_q,
    output logic field_oe_q,
    output logic pll_sync_q,
    output logic sp_sync_q,
    // power and misc
    output logic powered_down_q,
    output logic [7:0] rsv_cfg_q
);
    import opc_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // pin is asserted for the programmed polarity
    function automatic logic pin_active(input logic lvl, input logic pol);
        pin_active = pol ? lvl : ~lvl;
    endfunction

    // formats that move blue lanes to the secondary port
    function automatic logic fmt_split(input logic [2:0] fmt);
        fmt_split = (fmt == OPC_FMT_422) || (fmt == OPC_FMT_DDR);
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] inp_pwr_q; // power and input control
    logic [7:0] out_fmt_q; // format, enables, drive, invert
    logic [7:0] clk_sync_q; // clock select, hiz, sync source
    logic [7:0] filt_win_q; // filter half-window in steps

    // writes land at once; fields steer logic next cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            inp_pwr_q <= RST_INP_PWR;
            out_fmt_q <= RST_OUT_FMT;
            clk_sync_q <= RST_CLK_SYNC;
            rsv_cfg_q <= RST_RSV_CFG;
            filt_win_q <= RST_FILT_WIN;
        end else if (reg_bus.wr) begin
            unique case (reg_bus.addr)
                OFS_INP_PWR: inp_pwr_q <= reg_bus.wdata;
                OFS_OUT_FMT: out_fmt_q <= reg_bus.wdata;
                OFS_CLK_SYNC: clk_sync_q <= reg_bus.wdata;
                OFS_RSV_CFG: rsv_cfg_q <= reg_bus.wdata;
                OFS_FILT_WIN: filt_win_q <= reg_bus.wdata;
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else if (reg_bus.rd) begin
            unique case (reg_bus.addr)
                OFS_INP_PWR: rdata_q <= inp_pwr_q;
                OFS_OUT_FMT: rdata_q <= out_fmt_q;
                OFS_CLK_SYNC: rdata_q <= clk_sync_q;
                OFS_RSV_CFG: rdata_q <= rsv_cfg_q;
                OFS_FILT_WIN: rdata_q <= filt_win_q;
                default: rdata_q <= 8'h00; // unmapped reads zero
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // field views
    logic [2:0] fmt;
    logic [1:0] cksel;
    assign fmt = out_fmt_q[B_FMT_HI:B_FMT_LO];
    assign cksel = clk_sync_q[B_CKS_HI:B_CKS_LO];

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [PIN_N-1:0] pin_meta_q; // first stage, read only below
    logic [PIN_N-1:0] pin_s_q; // safe sampled levels
    logic [PIN_N-1:0] pin_prev_q; // for edge finding
    opc_pix_s pa_meta_q, pa_s_q;
    opc_pix_s pb_meta_q, pb_s_q;

    // two flops on every pin from the far side
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_q <= '0;
            pin_s_q <= '0;
            pin_prev_q <= '0;
            pa_meta_q <= '0;
            pa_s_q <= '0;
            pb_meta_q <= '0;
            pb_s_q <= '0;
        end else begin
            pin_meta_q <= pins;
            pin_s_q <= pin_meta_q;
            pin_prev_q <= pin_s_q;
            pa_meta_q <= pix_a;
            pa_s_q <= pa_meta_q;
            pb_meta_q <= pix_b;
            pb_s_q <= pb_meta_q;
        end
    end

    // pixel clock edges, found by oversampling
    logic pclk_rise, pclk_fall, regen_lead;
    assign pclk_rise = pin_s_q[PIN_PCLK] & ~pin_prev_q[PIN_PCLK];
    assign pclk_fall = ~pin_s_q[PIN_PCLK] & pin_prev_q[PIN_PCLK];
    assign regen_lead = pin_s_q[PIN_REGHS] & ~pin_prev_q[PIN_REGHS];

    // ----------------------------------------
    // power-down decision
    // ----------------------------------------
    logic pd_req; // combined power-down request
    logic fast_sw; // fast switching selected
    always_comb begin
        if (inp_pwr_q[B_PD_AUTO]) begin
            // chip decides; bit and pin ignored
            pd_req = auto_pd;
        end else begin
            // bit forces, else pin at its polarity
            pd_req = inp_pwr_q[B_PD_BIT] |
                pin_active(pin_s_q[PIN_PD], inp_pwr_q[B_PD_POL]);
        end
    end
    assign fast_sw = inp_pwr_q[B_PD_FAST];

    // fast switching keeps the core alive
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            powered_down_q <= 1'b0;
        end else begin
            powered_down_q <= pd_req & ~fast_sw;
        end
    end

    // ----------------------------------------
    // output enables
    // ----------------------------------------
    logic all_hiz; // everything but green sync floats
    assign all_hiz = clk_sync_q[B_ALL_HIZ] | pd_req;

    // both power-down kinds float the data pins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pri_oe_q <= 1'b0;
            sec_oe_q <= 1'b0;
            clk_oe_q <= 1'b0;
            field_oe_q <= 1'b0;
            green_sync_oe_q <= 1'b0;
        end else begin
            pri_oe_q <= out_fmt_q[B_PRI_EN] & ~all_hiz;
            // secondary only exists in split formats
            sec_oe_q <= out_fmt_q[B_SEC_EN] & fmt_split(fmt) & ~all_hiz;
            clk_oe_q <= ~all_hiz;
            field_oe_q <= ~all_hiz;
            // green sync ignores the global bit
            green_sync_oe_q <= ~clk_sync_q[B_GS_HIZ] &
                ~(pd_req & inp_pwr_q[B_GS_PDTRI]);
        end
    end

    // drive code; the field output has a fixed drive
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            drive_q <= RST_OUT_FMT[B_DRV_HI:B_DRV_LO];
        end else begin
            drive_q <= out_fmt_q[B_DRV_HI:B_DRV_LO];
        end
    end

    // ----------------------------------------
    // pixel formatter
    // ----------------------------------------
    // updates on sampled pixel clock edges
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pix_out_q <= '0;
        end else begin
            unique case (fmt)
                OPC_FMT_422: begin
                    // all 24 primary lines on the rise, blue included
                    if (pclk_rise) begin
                        pix_out_q.red <= pa_s_q.red;
                        pix_out_q.green <= pa_s_q.green;
                        pix_out_q.blue <= pa_s_q.blue;
                    end else if (pclk_fall) begin
                        // secondary is always double rate
                        pix_out_q.blue <= pb_s_q.blue;
                    end
                end
                OPC_FMT_DDR: begin
                    // new word on each clock edge
                    if (pclk_rise) begin
                        pix_out_q <= pa_s_q;
                    end else if (pclk_fall) begin
                        pix_out_q <= pb_s_q;
                    end
                end
                default: begin
                    // plain rgb, also for unused codes
                    if (pclk_rise) begin
                        pix_out_q <= pa_s_q;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // output clock
    // ----------------------------------------
    // only half the system rate can be made here
    logic int_clk_q;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            int_clk_q <= 1'b0;
        end else begin
            int_clk_q <= ~int_clk_q;
        end
    end

    // select then invert
    logic ck_pick;
    always_comb begin
        unique case (cksel)
            OPC_CK_PIX: ck_pick = pin_s_q[PIN_PCLK];
            OPC_CK_P90: ck_pick = pin_s_q[PIN_P90];
            OPC_CK_P2X: ck_pick = pin_s_q[PIN_P2X];
            OPC_CK_INT: ck_pick = int_clk_q;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clk_out_q <= 1'b0;
        end else begin
            clk_out_q <= ck_pick ^ out_fmt_q[B_CLK_INV];
        end
    end

    // ----------------------------------------
    // field and green sync
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            field_out_q <= 1'b0;
            green_sync_out_q <= 1'b0;
        end else begin
            // input high means odd field
            field_out_q <= pin_s_q[PIN_FIELD] ^ clk_sync_q[B_FLD_POL];
            green_sync_out_q <= pin_s_q[PIN_GSYNC];
        end
    end

    // ----------------------------------------
    // sync filter
    // ----------------------------------------
    logic [11:0] cnt_q; // cycles since regenerated lead
    logic [11:0] period_q; // last measured line length
    logic [11:0] win_cyc; // half-window in cycles
    logic in_win;
    assign win_cyc = 12'(filt_win_q) * 12'(FILT_STEP_CYC);
    // open just after the lead or just before the next
    assign in_win = (cnt_q <= win_cyc) || (12'(cnt_q + win_cyc) >= period_q);

    // period only tracked while regenerated sync runs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            period_q <= '0;
        end else if (regen_lead) begin
            cnt_q <= '0;
            period_q <= cnt_q;
        end else if (cnt_q != 12'hFFF) begin
            cnt_q <= cnt_q + 12'h001;
        end
    end

    // source selection for pll and sync processor
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pll_sync_q <= 1'b0;
            sp_sync_q <= 1'b0;
        end else begin
            pll_sync_q <= clk_sync_q[B_PLL_FILT] ?
                (pin_s_q[PIN_RAWHS] & in_win) : pin_s_q[PIN_RAWHS];
            sp_sync_q <= clk_sync_q[B_SP_REGEN] ?
                pin_s_q[PIN_REGHS] : pin_s_q[PIN_RAWHS];
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // arms the checks one edge after reset lets go, so no attempt
    // compares against values that reset still held at that edge
    logic chk_arm_q;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            chk_arm_q <= 1'b0;
        end else begin
            chk_arm_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n || !chk_arm_q);

    a_auto_pd_follow: assert property (
        inp_pwr_q[B_PD_AUTO] && !fast_sw |=> powered_down_q == $past(auto_pd))
        else $error("auto power-down not followed");
    a_bit_forces_pd: assert property (
        !inp_pwr_q[B_PD_AUTO] && inp_pwr_q[B_PD_BIT] && !fast_sw |=> powered_down_q)
        else $error("power-down bit ignored");
    a_pin_polarity: assert property (
        !inp_pwr_q[B_PD_AUTO] && !inp_pwr_q[B_PD_BIT] && !fast_sw |=>
        powered_down_q == $past(pin_s_q[PIN_PD] == inp_pwr_q[B_PD_POL]))
        else $error("power-down pin polarity wrong");
    a_fast_switch: assert property (
        pd_req && fast_sw |=> !powered_down_q && !pri_oe_q && !sec_oe_q)
        else $error("fast switching not honoured");
    a_gsync_pd_tri: assert property (
        pd_req && inp_pwr_q[B_GS_PDTRI] |=> !green_sync_oe_q)
        else $error("green sync driven in power-down");
    a_gsync_hiz: assert property (
        !clk_sync_q[B_GS_HIZ] && !pd_req |=> green_sync_oe_q)
        else $error("green sync not driven");
    a_global_hiz: assert property (
        clk_sync_q[B_ALL_HIZ] |=> !pri_oe_q && !clk_oe_q && !field_oe_q)
        else $error("outputs driven under global tri-state");
    a_sec_split: assert property (
        !fmt_split(fmt) |=> !sec_oe_q)
        else $error("secondary driven in rgb format");
    a_field_pol: assert property (
        ##1 field_out_q == ($past(pin_s_q[PIN_FIELD]) ^ $past(clk_sync_q[B_FLD_POL])))
        else $error("field polarity wrong");
    a_clk_invert: assert property (
        ##1 clk_out_q == ($past(ck_pick) ^ $past(out_fmt_q[B_CLK_INV])))
        else $error("clock inversion wrong");
    a_pll_raw: assert property (
        !clk_sync_q[B_PLL_FILT] |=> pll_sync_q == $past(pin_s_q[PIN_RAWHS]))
        else $error("pll not fed raw sync");
    a_write_lands: assert property (
        reg_bus.wr && reg_bus.addr == OFS_OUT_FMT |=> out_fmt_q == $past(reg_bus.wdata))
        else $error("register write lost");
endmodule

// ### testbench/opc_sink.sv
`timescale 1ns/1ps
// ----
// downstream pixel receiver model
// ----
module opc_sink
    import opc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // link from the digitizer
    input wire opc_pkg::opc_pix_s pix,
    input wire logic pix_oe,
    input wire logic clk_link,
    // what was latched
    output opc_pkg::opc_pix_s rise_word_q,
    output opc_pkg::opc_pix_s fall_word_q,
    output logic [15:0] rise_cnt_q
);
    import opc_pkg::*;

    logic clk_now_q; // sampled link clock
    logic clk_old_q; // one sample older
    // latch a cycle after each edge, so lanes moving with it have settled
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clk_now_q <= 1'b0;
            clk_old_q <= 1'b0;
            rise_word_q <= '0;
            fall_word_q <= '0;
            rise_cnt_q <= '0;
        end else begin
            clk_now_q <= clk_link;
            clk_old_q <= clk_now_q;
            // a floating bus is never latched
            if (clk_now_q && !clk_old_q && pix_oe) begin
                rise_word_q <= pix;
            end
            if (!clk_now_q && clk_old_q && pix_oe) begin
                fall_word_q <= pix;
            end
            if (clk_now_q && !clk_old_q) begin
                rise_cnt_q <= rise_cnt_q + 16'h0001;
            end
        end
    end
endmodule

// ### testbench/opc_ctrl_tb_top.sv
`timescale 1ns/1ps
module opc_ctrl_tb_top;
    import opc_pkg::*;
    // ----
    // stimulus and observed signals
    // ----
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    opc_bus_s bus = '0;
    logic auto_pd_in = 1'b0;
    opc_pix_s pix_a = '0;
    opc_pix_s pix_b = '0;
    logic pd_pin = 1'b1; // inactive for the reset polarity
    logic raw_hs = 1'b0, regen_hs = 1'b0, field_in = 1'b0, gsync_in = 1'b0;
    logic link_run = 1'b0; // link clocks stand still when low
    logic [1:0] ph = 2'b00; // link clock phase
    integer seed = 32'hA485DA98;
    int n_fail = 0;
    int comparisons = 0;
    logic [7:0] exp_q[$]; // expected read data, oldest first
    logic rd_d = 1'b0;
    logic [7:0] rdata_q, rsv_q, r;
    logic [1:0] drive;
    opc_pix_s pix_out, rise_w, fall_w, fexp;
    logic pri_oe, sec_oe, clk_out, clk_oe, gs_out, gs_oe, fld_out, fld_oe, pll_s, sp_s, pdn;
    logic [15:0] rcnt, c0;
    logic [2:0] fmt;
    localparam logic [7:0] OFSL[4] = '{8'h1E, 8'h1F, 8'h20, 8'h23};
    localparam logic [2:0] FMTS[4] = '{3'b100, 3'b101, 3'b110, 3'b100};
    localparam int RISES[4] = '{10, 10, 20, 40}; // per 80 cycles
    // 200 ns pixel clock, 90 degree copy, double rate copy
    always #12.5 clk_sys = ~clk_sys;
    always #50 ph <= link_run ? ph + 2'b01 : 2'b00;
    opc_ctrl u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_bus(bus), .rdata_q(rdata_q),
        .pins({gsync_in, field_in, regen_hs, raw_hs, ph[0], ^ph, ph[1], pd_pin}),
        .auto_pd(auto_pd_in), .pix_a(pix_a), .pix_b(pix_b), .pix_out_q(pix_out),
        .pri_oe_q(pri_oe), .sec_oe_q(sec_oe), .drive_q(drive), .clk_out_q(clk_out),
        .clk_oe_q(clk_oe), .green_sync_out_q(gs_out), .green_sync_oe_q(gs_oe),
        .field_out_q(fld_out), .field_oe_q(fld_oe), .pll_sync_q(pll_s), .sp_sync_q(sp_s),
        .powered_down_q(pdn), .rsv_cfg_q(rsv_q));
    opc_sink u_sink (.clk_sys(clk_sys), .reset_n(reset_n), .pix(pix_out), .pix_oe(pri_oe),
        .clk_link(clk_out), .rise_word_q(rise_w), .fall_word_q(fall_w), .rise_cnt_q(rcnt));
    // ----
    // helpers
    // ----
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({23'h0, got}, {23'h0, exp});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask
    // the note goes in now, the watcher compares a cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge clk_sys);
        bus.rd <= 1'b0;
    endtask
    task automatic end_sim();
        if (n_fail == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rd_d) begin
            chk({16'h0, rdata_q}, {16'h0, exp_q.pop_front()});
        end
        rd_d <= bus.rd;
    end
    // cut a hang short
    initial begin
        #200_000;
        n_fail++;
        end_sim();
    end
    // ----
    // main sequence
    // ----
    initial begin
        wt(8);
        reset_n <= 1'b1;
        rd(OFS_INP_PWR, 8'h20);
        rd(OFS_OUT_FMT, 8'h94);
        rd(OFS_CLK_SYNC, 8'h08);
        rd(OFS_RSV_CFG, 8'h00);
        rd(OFS_FILT_WIN, 8'h0A);
        rd(8'h22, 8'h00);
        chk({22'h0, drive}, 24'h2);
        chk1(pri_oe, 1'b1);
        chk1(sec_oe, 1'b0);
        foreach (OFSL[k]) begin
            r = $random(seed);
            wr(OFSL[k], r);
            rd(OFSL[k], r);
        end
        wr(OFS_RSV_CFG, 8'h00);
        wr(8'h22, 8'h5A);
        rd(8'h22, 8'h00);
        chk({16'h0, rsv_q}, 24'h0);
        wr(OFS_OUT_FMT, 8'h94);
        wr(OFS_CLK_SYNC, 8'h08);
        // the filter test below relies on the default window again
        wr(OFS_FILT_WIN, 8'h0A);
        // every mix of select, bit, polarity, fast switch and green tri-state
        for (int i = 0; i < 32; i++) begin
            r = $random(seed);
            pd_pin <= r[0];
            auto_pd_in <= r[1];
            wr(OFS_INP_PWR, {3'b001, i[4:0]});
            wt(5);
            fexp[0] = i[4] ? r[1] : (i[3] | (r[0] == i[2]));
            chk1(pdn, fexp[0] & ~i[1]);
            chk1(pri_oe, ~fexp[0]);
            chk1(gs_oe, ~(fexp[0] & i[0]));
        end
        pd_pin <= 1'b1;
        wr(OFS_INP_PWR, 8'h20);
        // formats and drive codes with the pixel clock running
        link_run <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            fmt = FMTS[k];
            pix_a <= $random(seed);
            pix_b <= $random(seed);
            wr(OFS_OUT_FMT, {fmt, 2'b11, k[1:0], 1'b0});
            wt(40);
            fexp = (fmt == OPC_FMT_DDR) ? pix_b : pix_a;
            fexp[7:0] = (fmt == OPC_FMT_444) ? pix_a[7:0] : pix_b[7:0];
            chk(rise_w, pix_a);
            chk(fall_w, fexp);
            chk1(sec_oe, fmt != OPC_FMT_444);
            chk({22'h0, drive}, {22'h0, k[1:0]});
        end
        wr(OFS_OUT_FMT, 8'h84);
        wt(4);
        chk1(pri_oe, 1'b0);
        wr(OFS_OUT_FMT, 8'h94);
        // output clock sources, counted as rising edges at the receiver
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CLK_SYNC, {s[1:0], 6'h08});
            wt(8);
            c0 = rcnt;
            wt(80);
            c0 = rcnt - c0;
            chk1(int'(c0) >= RISES[s] - 1 && int'(c0) <= RISES[s] + 1, 1'b1);
        end
        link_run <= 1'b0;
        wr(OFS_CLK_SYNC, 8'h08);
        wr(OFS_OUT_FMT, 8'h95);
        wt(6);
        chk1(clk_out, 1'b1);
        wr(OFS_OUT_FMT, 8'h94);
        wt(4);
        chk1(clk_out, 1'b0);
        // field polarity and sync routing
        for (int j = 0; j < 8; j++) begin
            r = $random(seed);
            field_in <= r[0];
            raw_hs <= r[1];
            regen_hs <= r[2];
            gsync_in <= r[3];
            wr(OFS_CLK_SYNC, {4'h0, j[0], 1'b0, j[1], 1'b0});
            wt(5);
            chk1(fld_out, r[0] ^ j[0]);
            chk1(pll_s, r[1]);
            chk1(sp_s, j[1] ? r[2] : r[1]);
            chk1(gs_out, r[3]);
        end
        // filter window: two leads 62 cycles apart, then sync just after the lead and in mid-line
        regen_hs <= 1'b0;
        raw_hs <= 1'b0;
        wr(OFS_CLK_SYNC, 8'h0C);
        for (int p = 0; p < 2; p++) begin
            wt(60);
            regen_hs <= 1'b1;
            wt(2);
            regen_hs <= 1'b0;
        end
        raw_hs <= 1'b1;
        wt(5);
        chk1(pll_s, 1'b1);
        wt(25);
        chk1(pll_s, 1'b0);
        // global and green tri-state
        wr(OFS_CLK_SYNC, 8'h28);
        wt(4);
        chk({20'h0, pri_oe, clk_oe, fld_oe, gs_oe}, 24'h1);
        wr(OFS_CLK_SYNC, 8'h18);
        wt(4);
        chk({22'h0, pri_oe, gs_oe}, 24'h2);
        wt(4);
        end_sim();
    end
endmodule
